// ==== hw/plrc_top.sv ====
// Local/remote control arbiter of the operator panel with panel setpoint generator.
`timescale 1ns/1ps
module plrc_top
	import plrc_pkg::*;
#(
	parameter int LINK_TO_CYC = PLRC_LINK_TIMEOUT_CYC,
	parameter int FLASH_HALF_CYC = PLRC_FLASH_HALF_CYC
)
(
	input wire logic CLK,
	input wire logic CE,
	input wire logic RESET,
	input wire logic KEY_MODE,
	input wire logic KEY_ON,
	input wire logic KEY_OFF,
	input wire logic KEY_JOG,
	input wire logic KEY_DIR,
	input wire logic KEY_UP,
	input wire logic KEY_DN,
	input wire logic KEY_ACK,
	input wire logic LINK_OK,
	input wire logic OP_LOCK,
	input wire logic CFG_RETAIN_MODE,
	input wire logic CFG_REMOTE_STOP,
	input wire logic CFG_SWITCH_RUN,
	input wire logic CFG_DIR_EN,
	input wire logic CFG_JOG_EN,
	input wire logic CFG_SP_SAVE,
	input wire logic CFG_PANEL_INHIBIT,
	input wire logic CFG_ACK_EN,
	input wire logic [1:0] CFG_STOP_TYPE,
	input wire logic [13:0] CFG_START_SP,
	input wire logic [15:0] CFG_RAMP_UP_MS,
	input wire logic [15:0] CFG_RAMP_DN_MS,
	input wire logic MC_INHIBIT,
	input wire logic DRV_OPERATION,
	input wire logic DRV_READY_ON,
	input wire logic signed [15:0] ACT_SPEED,
	input wire logic [10:0] EXT_CW,
	input wire logic [13:0] SP_ENTRY,
	input wire logic SP_ENTRY_OK,
	input wire logic NV_MODE_LOCAL,
	input wire logic [13:0] NV_SP,
	output logic PANEL_MASTER,
	output logic LAMP,
	output logic SUPPL_SP_EN,
	output logic [10:0] CTRL_WORD,
	output logic signed [15:0] SETPOINT,
	output logic MODE_ERR,
	output logic LINK_TRIP,
	output logic NV_MODE_WR,
	output logic [13:0] NV_SP_OUT,
	output logic NV_SP_WR
);
	typedef struct packed {
		plrc_state_t st;
		logic [K_NUM-1:0] s1;
		logic [K_NUM-1:0] s2;
		logic [K_NUM-1:0] prev;
		logic local_m;
		logic on;
		logic ccw;
		logic rstop;
		logic trip;
		logic jog;
		logic ack;
		logic err;
		logic mode_wr;
		logic sp_wr;
		logic [13:0] mag;
		logic [13:0] store;
		logic [31:0] lcnt;
		logic [31:0] fcnt;
		logic flash;
		logic lamp;
		logic suppl;
		logic [10:0] cw;
		logic [15:0] sp;
	} plrc_st_t;

	plrc_st_t q, d;
	logic [K_NUM-1:0] pins;
	logic [K_NUM-1:0] rise;
	logic [K_NUM-1:0] fall;
	logic keys_ok;
	logic tick;
	logic [21:0] interval;
	logic [13:0] act_mag;
	logic [15:0] act_abs;
	logic [14:0] up_sum;

	assign pins = {LINK_OK, KEY_ACK, KEY_DN, KEY_UP, KEY_DIR, KEY_JOG, KEY_OFF, KEY_ON, KEY_MODE};
	assign rise = q.s2 & ~q.prev;
	assign fall = ~q.s2 & q.prev;
	assign keys_ok = q.local_m & ~OP_LOCK;
	assign act_abs = ACT_SPEED[15] ? 16'(-ACT_SPEED) : 16'(ACT_SPEED);
	assign act_mag = (act_abs > 16'(PLRC_FULL_SCALE)) ? PLRC_FULL_SCALE : act_abs[13:0];
	assign up_sum = {1'b0, q.mag} + {1'b0, PLRC_STEP_1PCT};
	assign interval = q.s2[K_UP] ? 22'(CFG_RAMP_UP_MS) * PLRC_TICK_PER_MS
		: 22'(CFG_RAMP_DN_MS) * PLRC_TICK_PER_MS;

	plrc_ramp_tick u_tick (
		.clk(CLK),
		.ce(CE),
		.reset(RESET),
		.run(keys_ok & (q.s2[K_UP] ^ q.s2[K_DN])),
		.interval(interval),
		.tick(tick)
	);

	always_comb
	begin
		d = q;
		d.s1 = pins;
		d.s2 = q.s1;
		d.prev = q.s2;
		d.err = 1'b0;
		d.ack = 1'b0;
		d.mode_wr = 1'b0;
		d.sp_wr = 1'b0;
		case (q.st)
			ST_INIT:
			begin
				// Stored mode and setpoint are caught once, just after reset release.
				d.local_m = CFG_RETAIN_MODE & NV_MODE_LOCAL & ~MC_INHIBIT & ~CFG_PANEL_INHIBIT;
				d.store = (NV_SP > PLRC_FULL_SCALE) ? PLRC_FULL_SCALE : NV_SP;
				d.st = ST_RUN;
			end
			ST_RUN:
			begin
				if (rise[K_MODE] && !CFG_PANEL_INHIBIT && !MC_INHIBIT && !OP_LOCK)
				begin
					if (DRV_OPERATION && !CFG_SWITCH_RUN)
						d.err = 1'b1;
					else if (q.local_m)
					begin
						d.local_m = 1'b0;
						d.mode_wr = 1'b1;
						if (!CFG_SWITCH_RUN)
						begin
							d.on = 1'b0;
							d.mag = 14'h0;
						end
					end
					else
					begin
						d.local_m = 1'b1;
						d.mode_wr = 1'b1;
						d.rstop = 1'b0;
						if (DRV_OPERATION)
						begin
							// A running drive keeps its speed: the panel takes over from the actual value.
							d.mag = act_mag;
							d.ccw = ACT_SPEED[15];
							d.on = 1'b1;
							if (CFG_SP_SAVE)
							begin
								d.store = act_mag;
								d.sp_wr = 1'b1;
							end
						end
						else if (CFG_SP_SAVE)
							d.mag = q.store;
					end
				end
				else if (MC_INHIBIT && q.local_m)
				begin
					d.local_m = 1'b0;
					d.mode_wr = 1'b1;
				end
				else if (keys_ok)
				begin
					if (rise[K_ON] && !q.on)
					begin
						d.on = 1'b1;
						d.mag = CFG_SP_SAVE ? q.store :
							((CFG_START_SP > PLRC_FULL_SCALE) ? PLRC_FULL_SCALE : CFG_START_SP);
					end
					if (rise[K_DIR] && CFG_DIR_EN)
						d.ccw = ~q.ccw;
					if (rise[K_UP] && !q.s2[K_DN])
						d.mag = (up_sum > {1'b0, PLRC_FULL_SCALE}) ? PLRC_FULL_SCALE : up_sum[13:0];
					else if (rise[K_DN] && !q.s2[K_UP])
						d.mag = (q.mag < PLRC_STEP_1PCT) ? 14'h0 : q.mag - PLRC_STEP_1PCT;
					else if (tick && q.s2[K_UP] && q.mag < PLRC_FULL_SCALE)
						d.mag = q.mag + 14'h1;
					else if (tick && q.s2[K_DN] && q.mag != 14'h0)
						d.mag = q.mag - 14'h1;
					if ((fall[K_UP] || fall[K_DN]) && CFG_SP_SAVE)
					begin
						d.store = q.mag;
						d.sp_wr = 1'b1;
					end
					if (SP_ENTRY_OK && SP_ENTRY <= PLRC_FULL_SCALE)
					begin
						d.mag = SP_ENTRY;
						if (CFG_SP_SAVE)
						begin
							d.store = SP_ENTRY;
							d.sp_wr = 1'b1;
						end
					end
				end
				if (rise[K_OFF] && (q.local_m || CFG_REMOTE_STOP))
				begin
					d.on = 1'b0;
					d.rstop = ~q.local_m;
				end
				// A stop forced on the external word holds until the external source drops its on bit.
				if (q.rstop && !EXT_CW[CW_ON] && !rise[K_OFF])
					d.rstop = 1'b0;
				d.jog = keys_ok & CFG_JOG_EN & DRV_READY_ON & ~DRV_OPERATION & q.s2[K_JOG];
				d.ack = rise[K_ACK] & CFG_ACK_EN;
				if (q.s2[K_LINK])
				begin
					d.lcnt = 32'h0;
					d.trip = 1'b0;
				end
				else if (q.lcnt < 32'(LINK_TO_CYC - 1))
					d.lcnt = q.lcnt + 32'h1;
				else if (q.local_m || CFG_REMOTE_STOP)
				begin
					d.trip = 1'b1;
					d.on = 1'b0;
				end
			end
			default:
				d.st = ST_INIT;
		endcase

		if (q.fcnt >= 32'(FLASH_HALF_CYC - 1))
		begin
			d.fcnt = 32'h0;
			d.flash = ~q.flash;
		end
		else
			d.fcnt = q.fcnt + 32'h1;
		d.lamp = CFG_REMOTE_STOP ? d.flash : d.local_m;
		d.suppl = ~d.local_m;

		if (d.local_m)
		begin
			// The external word is not looked at in panel mode.
			d.cw = CW_PANEL_BASE;
			d.cw[CW_ON] = d.on & ~d.trip;
			d.cw[CW_NO_COAST] = d.on | (CFG_STOP_TYPE != STOP_COAST);
			d.cw[CW_NO_QSTOP] = d.on | (CFG_STOP_TYPE != STOP_QUICK);
			d.cw[CW_ACK] = d.ack;
			d.cw[CW_JOG] = d.jog;
		end
		else
		begin
			d.cw = EXT_CW;
			if (d.rstop || d.trip)
			begin
				d.cw[CW_ON] = 1'b0;
				if (CFG_STOP_TYPE == STOP_COAST)
					d.cw[CW_NO_COAST] = 1'b0;
				if (CFG_STOP_TYPE == STOP_QUICK)
					d.cw[CW_NO_QSTOP] = 1'b0;
			end
			d.cw[CW_ACK] = EXT_CW[CW_ACK] | d.ack;
		end
		// Magnitude stays unipolar; only the output word carries the sign.
		d.sp = !d.local_m ? 16'h0 : (d.ccw ? 16'(-{2'b00, d.mag}) : {2'b00, d.mag});
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			q <= '0;
		else if (CE)
			q <= d;
	end

	assign PANEL_MASTER = q.local_m;
	assign LAMP = q.lamp;
	assign SUPPL_SP_EN = q.suppl;
	assign CTRL_WORD = q.cw;
	assign SETPOINT = q.sp;
	assign MODE_ERR = q.err;
	assign LINK_TRIP = q.trip;
	assign NV_MODE_WR = q.mode_wr;
	assign NV_SP_OUT = q.store;
	assign NV_SP_WR = q.sp_wr;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET || !CE);

	a_lamp_mode: assert property (!CFG_REMOTE_STOP ##1 !CFG_REMOTE_STOP |-> LAMP == PANEL_MASTER)
		else $error("mode lamp does not follow panel mode");
	a_ext_masked: assert property (PANEL_MASTER |-> CTRL_WORD[6:3] == 4'hf && !SUPPL_SP_EN)
		else $error("external word or supplementary setpoint active in panel mode");
	a_ext_pass: assert property (##1 !PANEL_MASTER |-> CTRL_WORD[10:8] == $past(EXT_CW[10:8]))
		else $error("external word not passed in remote mode");
	a_mode_refuse: assert property (q.st == ST_RUN && rise[K_MODE] && DRV_OPERATION && !CFG_SWITCH_RUN
		&& !CFG_PANEL_INHIBIT && !MC_INHIBIT && !OP_LOCK |=> MODE_ERR && $stable(PANEL_MASTER))
		else $error("mode change in operation not refused");
	a_remote_off: assert property ($fell(PANEL_MASTER) && !$past(CFG_SWITCH_RUN) && !$past(MC_INHIBIT)
		|-> !q.on && q.mag == 14'h0)
		else $error("change to remote left drive on or setpoint set");
	a_on_gated: assert property ($rose(q.on) |-> !$past(OP_LOCK))
		else $error("switch-on under operator lock");
	a_jog_gate: assert property (##1 PANEL_MASTER && CTRL_WORD[CW_JOG]
		|-> $past(DRV_READY_ON && !DRV_OPERATION && CFG_JOG_EN))
		else $error("jog outside ready state");
	a_sp_range: assert property (q.mag <= PLRC_FULL_SCALE)
		else $error("panel setpoint above maximum speed");
	a_sp_sign: assert property (PANEL_MASTER && q.mag != 14'h0 |-> SETPOINT[15] == q.ccw)
		else $error("setpoint sign differs from direction");
	a_link_trip: assert property (LINK_TRIP |-> !$past(q.s2[K_LINK]) && !CTRL_WORD[CW_ON])
		else $error("link trip without link loss");

	c_to_panel: cover property ($rose(PANEL_MASTER));
	c_mode_err: cover property (MODE_ERR);
	c_link_trip: cover property ($rose(LINK_TRIP));
	c_jog: cover property (PANEL_MASTER && CTRL_WORD[CW_JOG]);
endmodule // plrc_top

// ==== hw/plrc_pkg.sv ====
// Package with constants and types of the panel local/remote control block.
package plrc_pkg;
	// Setpoint magnitude is held in 0.01 % of maximum speed.
	localparam logic [13:0] PLRC_FULL_SCALE = 14'h2710;
	localparam logic [13:0] PLRC_STEP_1PCT = 14'h0064;
	localparam logic [13:0] PLRC_START_SP_DEF = 14'h0000;
	localparam int PLRC_CLK_KHZ = 250000;
	// Cycles per setpoint count for each millisecond of full-scale ramp time.
	localparam logic [21:0] PLRC_TICK_PER_MS = 22'(PLRC_CLK_KHZ / 10000);
	localparam logic [15:0] PLRC_RAMP_UP_MS_DEF = 16'h4e20;
	localparam logic [15:0] PLRC_RAMP_DN_MS_DEF = 16'h7530;
	localparam int PLRC_LINK_TIMEOUT_MS = 1000;
	localparam int PLRC_LINK_TIMEOUT_CYC = PLRC_LINK_TIMEOUT_MS * PLRC_CLK_KHZ;
	localparam int PLRC_FLASH_HALF_MS = 250;
	localparam int PLRC_FLASH_HALF_CYC = PLRC_FLASH_HALF_MS * PLRC_CLK_KHZ;
	// Key and link pin positions in the synchronised input vector.
	localparam int K_MODE = 0;
	localparam int K_ON = 1;
	localparam int K_OFF = 2;
	localparam int K_JOG = 3;
	localparam int K_DIR = 4;
	localparam int K_UP = 5;
	localparam int K_DN = 6;
	localparam int K_ACK = 7;
	localparam int K_LINK = 8;
	localparam int K_NUM = 9;
	// Control word bit positions.
	localparam int CW_ON = 0;
	localparam int CW_NO_COAST = 1;
	localparam int CW_NO_QSTOP = 2;
	localparam int CW_ACK = 7;
	localparam int CW_JOG = 8;
	localparam logic [10:0] CW_PANEL_BASE = 11'h47e;
	localparam logic [1:0] STOP_RAMP = 2'h0;
	localparam logic [1:0] STOP_COAST = 2'h1;
	localparam logic [1:0] STOP_QUICK = 2'h2;
	typedef enum logic [0:0] {ST_INIT, ST_RUN} plrc_state_t;
endpackage

// ==== hw/plrc_ramp_tick.sv ====
// Interval timer that paces the held-key setpoint ramp.
`timescale 1ns/1ps
module plrc_ramp_tick
	import plrc_pkg::*;
(
	input wire logic clk,
	input wire logic ce,
	input wire logic reset,
	input wire logic run,
	input wire logic [21:0] interval,
	output logic tick
);
	typedef struct packed {
		logic [21:0] cnt;
		logic tick;
	} plrc_tick_st_t;

	plrc_tick_st_t q, d;

	always_comb
	begin
		d = q;
		d.tick = 1'b0;
		// The count restarts whenever the key is let go, so each hold begins a full interval.
		if (!run)
			d.cnt = 22'h0;
		else if (q.cnt + 22'h1 >= interval)
		begin
			d.cnt = 22'h0;
			d.tick = 1'b1;
		end
		else
			d.cnt = q.cnt + 22'h1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			q <= '0;
		else if (ce)
			q <= d;
	end

	assign tick = q.tick;
endmodule // plrc_ramp_tick

// ==== tb/plrc_drive_model.sv ====
// Behavioural model of the drive sequence control that sits behind the panel block.
`timescale 1ns/1ps
module plrc_drive_model
(
	input wire logic clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic [10:0] ctrl_word,
	input wire logic signed [15:0] run_speed,
	output logic operation,
	output logic ready_on,
	output logic signed [15:0] act_speed
);
	// The drive only runs with on set and neither stop bit pulled low, and it may react late.
	logic [2:0] on_q;
	always_ff @(posedge clk)
	begin
		if (reset)
			on_q <= 3'h0;
		else
			on_q <= {on_q[1:0], ctrl_word[0] & ctrl_word[1] & ctrl_word[2]};
	end
	assign operation = slow ? on_q[2] : on_q[0];
	assign ready_on = !operation;
	assign act_speed = operation ? run_speed : 16'sh0000;
endmodule // plrc_drive_model

// ==== tb/tb_top.sv ====
// Self-checking testbench of the panel local/remote control block.
`timescale 1ns/1ps
module tb_top;
	import plrc_pkg::*;
	logic CLK = 1'b0, CE = 1'b1, RESET = 1'b1, LINK_OK = 1'b1, OP_LOCK = 1'b0, MC_INHIBIT = 1'b0;
	logic CFG_RETAIN_MODE = 1'b1, CFG_REMOTE_STOP = 1'b0, CFG_SWITCH_RUN = 1'b0, CFG_DIR_EN = 1'b0;
	logic CFG_JOG_EN = 1'b0, CFG_SP_SAVE = 1'b0, CFG_PANEL_INHIBIT = 1'b0, CFG_ACK_EN = 1'b1;
	logic SP_ENTRY_OK = 1'b0, NV_MODE_LOCAL = 1'b1, slow = 1'b0, DRV_OPERATION, DRV_READY_ON;
	logic [7:0] k = 8'h00;
	logic [1:0] CFG_STOP_TYPE = 2'h0;
	logic [13:0] CFG_START_SP = 14'h01f4, SP_ENTRY = 14'h0000, NV_SP = 14'h0000, NV_SP_OUT;
	logic [15:0] CFG_RAMP_UP_MS = 16'h0001, CFG_RAMP_DN_MS = 16'h0002;
	logic signed [15:0] ACT_SPEED, SETPOINT, run_speed = 16'sh04d2;
	logic [10:0] EXT_CW = 11'h2a5, CTRL_WORD;
	logic PANEL_MASTER, LAMP, SUPPL_SP_EN, MODE_ERR, LINK_TRIP, NV_MODE_WR, NV_SP_WR;
	int err_total = 0, check_count = 0, merr = 0, spwr = 0, ackp = 0, mwr = 0, n;

	plrc_top #(.LINK_TO_CYC(20), .FLASH_HALF_CYC(4)) dut
	(
		.KEY_MODE(k[0]), .KEY_ON(k[1]), .KEY_OFF(k[2]), .KEY_JOG(k[3]),
		.KEY_DIR(k[4]), .KEY_UP(k[5]), .KEY_DN(k[6]), .KEY_ACK(k[7]),
		.CLK(CLK), .CE(CE), .RESET(RESET), .LINK_OK(LINK_OK), .OP_LOCK(OP_LOCK),
		.CFG_RETAIN_MODE(CFG_RETAIN_MODE), .CFG_REMOTE_STOP(CFG_REMOTE_STOP), .CFG_SWITCH_RUN(CFG_SWITCH_RUN),
		.CFG_DIR_EN(CFG_DIR_EN), .CFG_JOG_EN(CFG_JOG_EN), .CFG_SP_SAVE(CFG_SP_SAVE),
		.CFG_PANEL_INHIBIT(CFG_PANEL_INHIBIT), .CFG_ACK_EN(CFG_ACK_EN), .CFG_STOP_TYPE(CFG_STOP_TYPE),
		.CFG_START_SP(CFG_START_SP), .CFG_RAMP_UP_MS(CFG_RAMP_UP_MS), .CFG_RAMP_DN_MS(CFG_RAMP_DN_MS),
		.MC_INHIBIT(MC_INHIBIT), .DRV_OPERATION(DRV_OPERATION), .DRV_READY_ON(DRV_READY_ON),
		.ACT_SPEED(ACT_SPEED), .EXT_CW(EXT_CW), .SP_ENTRY(SP_ENTRY), .SP_ENTRY_OK(SP_ENTRY_OK),
		.NV_MODE_LOCAL(NV_MODE_LOCAL), .NV_SP(NV_SP), .PANEL_MASTER(PANEL_MASTER), .LAMP(LAMP),
		.SUPPL_SP_EN(SUPPL_SP_EN), .CTRL_WORD(CTRL_WORD), .SETPOINT(SETPOINT), .MODE_ERR(MODE_ERR),
		.LINK_TRIP(LINK_TRIP), .NV_MODE_WR(NV_MODE_WR), .NV_SP_OUT(NV_SP_OUT), .NV_SP_WR(NV_SP_WR)
	);
	plrc_drive_model drv
	(
		.clk(CLK), .reset(RESET), .slow(slow), .ctrl_word(CTRL_WORD), .run_speed(run_speed),
		.operation(DRV_OPERATION), .ready_on(DRV_READY_ON), .act_speed(ACT_SPEED)
	);

	initial
	begin
		forever #2 CLK = ~CLK;
	end

	// One-cycle pulses are counted here so that no scenario has to hit their exact cycle.
	always @(posedge CLK)
	begin
		if (MODE_ERR === 1'b1)
			merr++;
		if (NV_SP_WR === 1'b1)
			spwr++;
		if (CTRL_WORD[7] === 1'b1)
			ackp++;
		if (NV_MODE_WR === 1'b1)
			mwr++;
	end

	task automatic final_report();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge CLK);
		#1;
	endtask

	// A key acts two edges after it is first sampled, so five edges of hold cover it.
	task automatic hold(input int i, input int c);
		@(posedge CLK);
		k[i] <= 1'b1;
		cyc(c);
		@(posedge CLK);
		k[i] <= 1'b0;
		cyc(4);
	endtask

	task automatic tap(input int i);
		hold(i, 4);
	endtask

	task automatic do_reset();
		@(posedge CLK);
		RESET <= 1'b1;
		@(posedge CLK);
		RESET <= 1'b0;
		cyc(3);
	endtask

	task automatic entry(input logic [13:0] v);
		@(posedge CLK);
		SP_ENTRY <= v;
		SP_ENTRY_OK <= 1'b1;
		@(posedge CLK);
		SP_ENTRY_OK <= 1'b0;
		cyc(2);
	endtask

	task automatic s_power();
		do_reset();
		check("retained mode", PANEL_MASTER, 1);
		@(posedge CLK);
		CFG_RETAIN_MODE <= 1'b0;
		do_reset();
		check("remote at start", PANEL_MASTER, 0);
		check("lamp dark", LAMP, 0);
		check("suppl enabled", SUPPL_SP_EN, 1);
		tap(1);
		check("remote cw", CTRL_WORD, EXT_CW);
		check("remote sp", SETPOINT, 0);
	endtask

	task automatic s_panel();
		logic [2:0] e[3];
		e = '{3'b110, 3'b100, 3'b010};
		tap(0);
		check("panel mode", PANEL_MASTER, 1);
		check("lamp lit", LAMP, 1);
		check("suppl off", SUPPL_SP_EN, 0);
		check("panel cw", CTRL_WORD, CW_PANEL_BASE);
		check("mode store", mwr, 1);
		@(posedge CLK);
		OP_LOCK <= 1'b1;
		tap(1);
		check("locked on", CTRL_WORD[0], 0);
		@(posedge CLK);
		OP_LOCK <= 1'b0;
		tap(1);
		check("on bit", CTRL_WORD[0], 1);
		check("start sp", SETPOINT, 16'h01f4);
		tap(5);
		check("step up", SETPOINT, 16'h0258);
		tap(4);
		check("dir inert", SETPOINT, 16'h0258);
		@(posedge CLK);
		CFG_DIR_EN <= 1'b1;
		tap(4);
		check("dir ccw", SETPOINT, 16'hfda8);
		tap(5);
		check("ccw faster", SETPOINT, 16'hfd44);
		tap(6);
		check("step down", SETPOINT, 16'hfda8);
		tap(5);
		hold(5, 112);
		check("ramp up", SETPOINT <= 16'shfcdf && SETPOINT >= 16'shfcdb, 1);
		check("no store", spwr, 0);
		hold(6, 112);
		check("ramp down", SETPOINT <= 16'shfd43 && SETPOINT >= 16'shfd41, 1);
		tap(0);
		check("run refuse", merr, 1);
		check("mode kept", PANEL_MASTER, 1);
		check("refused no store", mwr, 1);
		entry(14'h2711);
		check("entry high", SETPOINT <= 16'shfd43 && SETPOINT >= 16'shfd41, 1);
		entry(14'h2710);
		check("entry max", SETPOINT, 16'hd8f0);
		for (int t = 0; t < 3; t++)
		begin
			@(posedge CLK);
			CFG_STOP_TYPE <= t[1:0];
			tap(2);
			check("stop type", CTRL_WORD[2:0], e[t]);
			tap(1);
		end
		tap(2);
		@(posedge CLK);
		CFG_JOG_EN <= 1'b1;
		k[3] <= 1'b1;
		cyc(5);
		check("jog bit", CTRL_WORD[8], 1);
		@(posedge CLK);
		k[3] <= 1'b0;
		cyc(4);
		tap(0);
		check("off to remote", PANEL_MASTER, 0);
		tap(0);
		check("sp zeroed", SETPOINT, 0);
		check("off stays off", CTRL_WORD[0], 0);
	endtask

	task automatic s_switch();
		@(posedge CLK);
		CFG_SWITCH_RUN <= 1'b1;
		slow <= 1'b1;
		tap(1);
		tap(0);
		check("run to remote", PANEL_MASTER, 0);
		@(posedge CLK);
		EXT_CW <= 11'h007;
		CFG_SP_SAVE <= 1'b1;
		cyc(6);
		n = spwr;
		tap(0);
		check("take actual", SETPOINT, 16'h04d2);
		check("actual stored", spwr, n + 1);
		tap(5);
		check("release store", NV_SP_OUT, 16'h0536);
		n = ackp;
		tap(7);
		check("ack pulse", ackp, n + 1);
		@(posedge CLK);
		CFG_ACK_EN <= 1'b0;
		tap(7);
		check("ack off", ackp, n + 1);
		@(posedge CLK);
		MC_INHIBIT <= 1'b1;
		cyc(3);
		check("mc inhibit", PANEL_MASTER, 0);
		check("inhibit store", mwr, 6);
		@(posedge CLK);
		MC_INHIBIT <= 1'b0;
		CFG_PANEL_INHIBIT <= 1'b1;
		tap(0);
		check("mode inhibit", PANEL_MASTER, 0);
		@(posedge CLK);
		CFG_PANEL_INHIBIT <= 1'b0;
		tap(2);
		check("remote off ign", CTRL_WORD[0], 1);
		@(posedge CLK);
		CFG_REMOTE_STOP <= 1'b1;
		n = 0;
		for (int c = 0; c < 12; c++)
		begin
			cyc(1);
			n += (LAMP === 1'b1);
		end
		check("lamp flash", n > 0 && n < 12, 1);
		tap(2);
		check("remote stop", CTRL_WORD[0], 0);
		@(posedge CLK);
		EXT_CW <= 11'h000;
		cyc(6);
		tap(0);
		check("stored on off", SETPOINT, 16'h0536);
		tap(1);
		@(posedge CLK);
		LINK_OK <= 1'b0;
		cyc(15);
		check("link early", LINK_TRIP, 0);
		cyc(15);
		check("link trip", LINK_TRIP, 1);
		check("trip off", CTRL_WORD[0], 0);
		@(posedge CLK);
		LINK_OK <= 1'b1;
		cyc(4);
		check("trip clear", LINK_TRIP, 0);
	endtask

	initial
	begin
		s_power();
		s_panel();
		s_switch();
		final_report();
	end

	initial
	begin
		repeat (20000) @(posedge CLK);
		err_total++;
		final_report();
	end
endmodule // tb_top
